// File: design/odu_pkg.sv
// Purpose: constants and types shared by the orientation detect unit
// Assumes: 10-bit signed samples at 2 g full scale (256 counts per g)
// Notes:   addresses, bit positions, reset values and thresholds are named here
package odu_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_CONFIG   = 8'h11;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h12;

    localparam int STAT_FLAG_BIT   = 7;
    localparam int STAT_LOCK_BIT   = 6;
    localparam int STAT_CODE_HI    = 2;
    localparam int STAT_CODE_LO    = 1;
    localparam int STAT_FACING_BIT = 0;
    localparam int CFG_MODE_BIT    = 7;
    localparam int CFG_ENABLE_BIT  = 6;

    localparam logic       RST_DEBOUNCE_MODE = 1'h1;
    localparam logic       RST_ENABLE        = 1'h0;
    localparam logic [7:0] RST_DEBOUNCE_VAL  = 8'h00;

    // ****************************************
    // modes and codes
    // ****************************************
    localparam logic [1:0] SYS_STANDBY = 2'h0;
    localparam logic [1:0] SYS_WAKE    = 2'h1;
    localparam logic [1:0] SYS_SLEEP   = 2'h2;

    localparam logic [1:0] CODE_PORTRAIT_UP   = 2'h0;
    localparam logic [1:0] CODE_PORTRAIT_DOWN = 2'h1;
    localparam logic [1:0] CODE_LAND_RIGHT    = 2'h2;
    localparam logic [1:0] CODE_LAND_LEFT     = 2'h3;

    localparam logic FACE_FRONT = 1'h0;
    localparam logic FACE_BACK  = 1'h1;

    localparam logic [1:0] OS_NORMAL  = 2'h0;
    localparam logic [1:0] OS_LPLN    = 2'h1;
    localparam logic [1:0] OS_HIGHRES = 2'h2;
    localparam logic [1:0] OS_LP      = 2'h3;

    // ****************************************
    // classification thresholds, counts of one sample or ratios
    // ****************************************
    localparam int SAMPLE_W = 10;
    localparam logic [9:0] OVERLOAD_LIMIT = 10'h140;  // 1.25 g
    localparam logic [9:0] FACING_HYST    = 10'h042;  // about 15 deg past level
    // tan(59 deg) ~ 27/16, for 45 deg split with 14 deg hysteresis
    localparam logic [5:0] TRIP_NUM = 6'h1B;
    localparam logic [5:0] TRIP_DEN = 6'h10;
    // tan^2(29 deg) ~ 31/100, z-lock angle
    localparam logic [6:0] LOCK_NUM = 7'h1F;
    localparam logic [6:0] LOCK_DEN = 7'h64;

    localparam logic [7:0] STEP_DIV_W8 = 8'h00;
endpackage

// File: design/odu_class_if.sv
// Purpose: carries samples, committed state and the new classification
// Assumes: single clock, purely combinational path through the classifier
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface odu_class_if;
    logic signed [9:0] accX;
    logic signed [9:0] accY;
    logic signed [9:0] accZ;
    logic        [1:0] curCode;
    logic              curFacing;
    logic        [1:0] newCode;
    logic              newFacing;
    logic              newLock;
    logic              overload;

    modport top (output accX, accY, accZ, curCode, curFacing,
                 input  newCode, newFacing, newLock, overload);
    modport cls (input  accX, accY, accZ, curCode, curFacing,
                 output newCode, newFacing, newLock, overload);
endinterface
`default_nettype wire

// File: design/odu_classifier.sv
// Purpose: classifies one sample into orientation code, facing and lockout
// Assumes: hysteresis is taken against the committed state
// Notes:   combinational
`timescale 1ns/1ps
`default_nettype none
module odu_classifier (
    odu_class_if.cls cif
);
    logic [9:0]  absX;
    logic [9:0]  absY;
    logic [9:0]  absZ;
    logic [15:0] scX;
    logic [15:0] scY;
    logic [15:0] trX;
    logic [15:0] trY;
    logic [27:0] sqXY;
    logic [27:0] sqZ;
    logic        curLand;
    logic        land;

    function automatic logic [9:0] absVal(input logic signed [9:0] v);
        absVal = v[9] ? 10'(-v) : 10'(v);
    endfunction

    always_comb begin
        absX = absVal(cif.accX);
        absY = absVal(cif.accY);
        absZ = absVal(cif.accZ);
        scX  = 16'(absX) * 16'(odu_pkg::TRIP_DEN);
        scY  = 16'(absY) * 16'(odu_pkg::TRIP_DEN);
        trX  = 16'(absX) * 16'(odu_pkg::TRIP_NUM);
        trY  = 16'(absY) * 16'(odu_pkg::TRIP_NUM);
        sqXY = (28'(absX) * 28'(absX) + 28'(absY) * 28'(absY)) * 28'(odu_pkg::LOCK_DEN);
        sqZ  = 28'(absZ) * 28'(absZ) * 28'(odu_pkg::LOCK_NUM);
    end

    // ****************************************
    // portrait/landscape with hysteresis around 45 degrees
    // ****************************************
    always_comb begin
        curLand = cif.curCode[1];
        if (curLand) begin
            land = !(trX < scY);
        end else begin
            land = (scX > trY);
        end
        if (land) begin
            cif.newCode = cif.accX[9] ? odu_pkg::CODE_LAND_LEFT
                                      : odu_pkg::CODE_LAND_RIGHT;
        end else begin
            cif.newCode = cif.accY[9] ? odu_pkg::CODE_PORTRAIT_DOWN
                                      : odu_pkg::CODE_PORTRAIT_UP;
        end
    end

    // ****************************************
    // facing, lockout and overload
    // ****************************************
    always_comb begin
        if (cif.curFacing == odu_pkg::FACE_FRONT) begin
            cif.newFacing = (cif.accZ[9] && absZ > odu_pkg::FACING_HYST) ?
                            odu_pkg::FACE_BACK : odu_pkg::FACE_FRONT;
        end else begin
            cif.newFacing = (!cif.accZ[9] && absZ > odu_pkg::FACING_HYST) ?
                            odu_pkg::FACE_FRONT : odu_pkg::FACE_BACK;
        end
        cif.newLock  = (sqXY < sqZ);
        cif.overload = (absX > odu_pkg::OVERLOAD_LIMIT) ||
                       (absY > odu_pkg::OVERLOAD_LIMIT) ||
                       (absZ > odu_pkg::OVERLOAD_LIMIT);
    end
endmodule
`default_nettype wire

// File: design/odu_top.sv
// Purpose: orientation detect unit with status, config and debounce registers
// Assumes: sampleStrobe pulses once per base conversion (1.25 ms), same clock
// Notes:   registers reached by a simple byte-wide read/write port
`timescale 1ns/1ps
`default_nettype none
module odu_top (
    input  wire  logic              clock,
    input  wire  logic              rst,
    input  wire  logic        [7:0] regAddr,
    input  wire  logic              regWrEn,
    input  wire  logic              regRdEn,
    input  wire  logic        [7:0] regWrData,
    output logic              [7:0] regRdData,
    input  wire  logic        [1:0] sysMode,
    input  wire  logic        [2:0] outputSampleRate,
    input  wire  logic        [1:0] overSampleMode,
    input  wire  logic              sampleStrobe,
    input  wire  logic signed [9:0] accX,
    input  wire  logic signed [9:0] accY,
    input  wire  logic signed [9:0] accZ,
    input  wire  logic              orientIrqEnable,
    output logic                    orientIrqSource
);
    // ****************************************
    // declarations
    // ****************************************
    odu_class_if cif ();

    logic       debounceMode_ff;
    logic       orientDetectEnable_ff;
    logic [7:0] debounceValue_ff;
    logic [7:0] rdData_ff;
    logic [1:0] orientCode_ff;
    logic       facingBit_ff;
    logic       tiltLockout_ff;
    logic       orientChangeFlag_ff;
    logic [7:0] dbCnt_ff;
    logic [7:0] stepCnt_ff;
    logic [1:0] prevMode_ff;
    logic       firstEval_ff;
    logic       active;
    logic       running;
    logic       modeSwap;
    logic       evalStrobe;
    logic       pending;
    logic       commit;
    logic       statusRead;
    logic [7:0] stepLen;

    // base conversions per debounce step, 1.25 ms units
    function automatic logic [7:0] stepTicks(input logic [2:0] output_sample_rate, input logic [1:0] os);
        logic [7:0] t;
        t = 8'h01;
        unique case (output_sample_rate)
            3'h0:    t = 8'h01;
            3'h1:    t = 8'h02;
            3'h2:    t = 8'h04;
            3'h3:    t = 8'h08;
            3'h4:    t = 8'h10;
            3'h5:    t = 8'h40;
            default: t = 8'h80;
        endcase
        if (os == odu_pkg::OS_HIGHRES && output_sample_rate != 3'h0) begin
            t = 8'h02;
        end else if (os == odu_pkg::OS_NORMAL && t > 8'h10) begin
            t = 8'h10;
        end else if (os == odu_pkg::OS_LPLN && t > 8'h40) begin
            t = 8'h40;
        end
        stepTicks = t;
    endfunction

    assign cif.accX      = accX;
    assign cif.accY      = accY;
    assign cif.accZ      = accZ;
    assign cif.curCode   = orientCode_ff;
    assign cif.curFacing = facingBit_ff;

    odu_classifier u_cls (
        .cif (cif)
    );

    // ****************************************
    // mode tracking and evaluation strobe
    // ****************************************
    assign active     = (sysMode != odu_pkg::SYS_STANDBY);
    assign running    = active && orientDetectEnable_ff;
    assign modeSwap   = (sysMode == odu_pkg::SYS_WAKE && prevMode_ff == odu_pkg::SYS_SLEEP) ||
                        (sysMode == odu_pkg::SYS_SLEEP && prevMode_ff == odu_pkg::SYS_WAKE);
    assign stepLen    = stepTicks(outputSampleRate, overSampleMode);
    assign evalStrobe = running && sampleStrobe &&
                        (stepCnt_ff + 8'h01 >= stepLen);
    assign statusRead = regRdEn && (regAddr == odu_pkg::ADDR_STATUS);

    always_ff @(posedge clock) begin
        if (rst) begin
            prevMode_ff <= odu_pkg::SYS_STANDBY;
        end else begin
            prevMode_ff <= sysMode;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !running || modeSwap) begin
            stepCnt_ff <= odu_pkg::STEP_DIV_W8;
        end else if (evalStrobe) begin
            stepCnt_ff <= odu_pkg::STEP_DIV_W8;
        end else if (sampleStrobe) begin
            stepCnt_ff <= stepCnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !active) begin
            firstEval_ff <= 1'h1;
        end else if (evalStrobe) begin
            firstEval_ff <= 1'h0;
        end
    end

    // ****************************************
    // debounce and commit
    // ****************************************
    // a code held under lockout is no change, else the flag would set on every step
    assign pending = !cif.overload &&
                     ((!cif.newLock && cif.newCode != orientCode_ff) ||
                      (cif.newFacing != facingBit_ff) ||
                      (cif.newLock != tiltLockout_ff));
    assign commit  = evalStrobe && pending &&
                     (firstEval_ff || dbCnt_ff >= debounceValue_ff);

    always_ff @(posedge clock) begin
        if (rst || !running || modeSwap) begin
            dbCnt_ff <= 8'h00;
        end else if (evalStrobe) begin
            if (commit) begin
                dbCnt_ff <= 8'h00;
            end else if (pending) begin
                if (dbCnt_ff != 8'hFF) begin
                    dbCnt_ff <= dbCnt_ff + 8'h01;
                end
            end else if (debounceMode_ff) begin
                dbCnt_ff <= 8'h00;
            end else if (dbCnt_ff != 8'h00) begin
                dbCnt_ff <= dbCnt_ff - 8'h01;
            end
        end
    end

    // state updates regardless of the flag
    always_ff @(posedge clock) begin
        if (rst) begin
            orientCode_ff  <= odu_pkg::CODE_PORTRAIT_UP;
            facingBit_ff   <= odu_pkg::FACE_FRONT;
            tiltLockout_ff <= 1'h0;
        end else if (commit) begin
            tiltLockout_ff <= cif.newLock;
            facingBit_ff   <= cif.newFacing;
            if (!cif.newLock) begin
                orientCode_ff <= cif.newCode;
            end
        end
    end

    // set wins over the read clear
    always_ff @(posedge clock) begin
        if (rst) begin
            orientChangeFlag_ff <= 1'h0;
        end else if (commit || (evalStrobe && firstEval_ff)) begin
            orientChangeFlag_ff <= 1'h1;
        end else if (statusRead) begin
            orientChangeFlag_ff <= 1'h0;
        end
    end

    assign orientIrqSource = orientChangeFlag_ff && orientIrqEnable;

    // ****************************************
    // register port
    // ****************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            debounceMode_ff       <= odu_pkg::RST_DEBOUNCE_MODE;
            orientDetectEnable_ff <= odu_pkg::RST_ENABLE;
        end else if (regWrEn && regAddr == odu_pkg::ADDR_CONFIG) begin
            debounceMode_ff       <= regWrData[odu_pkg::CFG_MODE_BIT];
            orientDetectEnable_ff <= regWrData[odu_pkg::CFG_ENABLE_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            debounceValue_ff <= odu_pkg::RST_DEBOUNCE_VAL;
        end else if (regWrEn && regAddr == odu_pkg::ADDR_DEBOUNCE) begin
            debounceValue_ff <= regWrData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdData_ff <= 8'h00;
        end else if (regRdEn) begin
            rdData_ff <= 8'h00;
            unique case (regAddr)
                odu_pkg::ADDR_STATUS: begin
                    rdData_ff[odu_pkg::STAT_FLAG_BIT]   <= orientChangeFlag_ff;
                    rdData_ff[odu_pkg::STAT_LOCK_BIT]   <= tiltLockout_ff;
                    rdData_ff[odu_pkg::STAT_CODE_HI:odu_pkg::STAT_CODE_LO] <= orientCode_ff;
                    rdData_ff[odu_pkg::STAT_FACING_BIT] <= facingBit_ff;
                end
                odu_pkg::ADDR_CONFIG: begin
                    rdData_ff[odu_pkg::CFG_MODE_BIT]   <= debounceMode_ff;
                    rdData_ff[odu_pkg::CFG_ENABLE_BIT] <= orientDetectEnable_ff;
                end
                odu_pkg::ADDR_DEBOUNCE: begin
                    rdData_ff <= debounceValue_ff;
                end
                default: begin
                    rdData_ff <= 8'h00;
                end
            endcase
        end
    end

    assign regRdData = rdData_ff;
endmodule
`default_nettype wire

// File: bench/odu_monitor.sv
// Purpose: concurrent checks on the ports of the orientation detect unit
// Assumes: one clock domain, synchronous active high reset
// Notes:   bound to odu_top from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module odu_monitor (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic        [7:0] regAddr,
    input wire logic              regWrEn,
    input wire logic              regRdEn,
    input wire logic        [7:0] regWrData,
    input wire logic        [7:0] regRdData,
    input wire logic        [1:0] sysMode,
    input wire logic        [2:0] outputSampleRate,
    input wire logic        [1:0] overSampleMode,
    input wire logic              sampleStrobe,
    input wire logic signed [9:0] accX,
    input wire logic signed [9:0] accY,
    input wire logic signed [9:0] accZ,
    input wire logic              orientIrqEnable,
    input wire logic              orientIrqSource
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic rdSt;
    logic rdUn;
    assign rdSt = regRdEn && (regAddr == odu_pkg::ADDR_STATUS);
    assign rdUn = regRdEn && (regAddr != odu_pkg::ADDR_STATUS)
                  && (regAddr != odu_pkg::ADDR_CONFIG) && (regAddr != odu_pkg::ADDR_DEBOUNCE);

    property p_irq_gate;
        !orientIrqEnable |-> !orientIrqSource;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq source without enable");
    property p_rd_clear;
        rdSt && orientIrqEnable && !sampleStrobe && !$past(sampleStrobe) ##1 orientIrqEnable
            |-> !orientIrqSource;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status read left irq set");
    property p_flag_hold;
        orientIrqSource && !rdSt ##1 orientIrqEnable |-> orientIrqSource;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost without read");
    property p_rst_vals;
        $fell(rst) |-> (regRdData == 8'h00) && !orientIrqSource;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not cleared by reset");
    property p_cfg_rsvd;
        regRdEn && (regAddr == odu_pkg::ADDR_CONFIG) |=> regRdData[5:0] == 6'h00;
    endproperty
    a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config spare bits set");
    property p_st_rsvd;
        rdSt |=> regRdData[5:3] == 3'h0;
    endproperty
    a_st_rsvd: assert property (p_st_rsvd) else $error("status spare bits set");
    property p_unmapped;
        rdUn |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rd_hold;
        !regRdEn |=> $stable(regRdData);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_cnt_rw;
        regWrEn && (regAddr == odu_pkg::ADDR_DEBOUNCE) ##1 !regWrEn
            ##1 regRdEn && !regWrEn && (regAddr == odu_pkg::ADDR_DEBOUNCE)
            |=> regRdData == $past(regWrData, 3);
    endproperty
    a_cnt_rw: assert property (p_cnt_rw) else $error("debounce count readback wrong");
    property p_rise_cause;
        $rose(orientIrqSource) && $past(orientIrqEnable)
            |-> $past(sampleStrobe) || $past(sampleStrobe, 2);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("flag set without sample");

    c_rd_irq: cover property (rdSt && orientIrqSource);
    c_cnt_wr: cover property (regWrEn && (regAddr == odu_pkg::ADDR_DEBOUNCE));
    c_irq_up: cover property ($rose(orientIrqSource));
endmodule
`default_nettype wire

// File: bench/odu_tb_top.sv
// Purpose: register level test of the orientation detect unit
// Assumes: 256 counts per g, inputs driven 1 ns after the rising edge
// Notes:   sequences of register and sample calls with expected values
`timescale 1ns/1ps
`default_nettype none
module odu_tb_top;
    localparam logic [9:0] P = 10'h100, N = 10'h300, Z0 = 10'h000;
    localparam logic [9:0] BK = 10'h39C, FR = 10'h064, OV = 10'h190;
    logic clock = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0, sampleStrobe = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [1:0] sysMode = odu_pkg::SYS_STANDBY, overSampleMode = odu_pkg::OS_NORMAL;
    logic [2:0] outputSampleRate = 3'h0;
    logic signed [9:0] accX = 10'h000, accY = 10'h000, accZ = 10'h000;
    logic orientIrqEnable = 1'b1, orientIrqSource;
    int mismatches = 0, nChecks = 0;

    always #2.5 clock = ~clock;

    odu_top dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .sysMode(sysMode),
        .outputSampleRate(outputSampleRate), .overSampleMode(overSampleMode),
        .sampleStrobe(sampleStrobe), .accX(accX), .accY(accY), .accZ(accZ),
        .orientIrqEnable(orientIrqEnable), .orientIrqSource(orientIrqSource));

    // ****************************************
    // access tasks and compares
    // ****************************************
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t irq got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock); #1;
        regAddr = a; regWrData = d; regWrEn = 1'b1;
        @(posedge clock); #1;
        regWrEn = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock); #1;
        regAddr = a; regRdEn = 1'b1;
        @(posedge clock); #1;
        regRdEn = 1'b0;
        chk8(regRdData, exp);
    endtask
    // one strobe with the given sample, then let the result land
    task automatic ev(input logic [9:0] x, input logic [9:0] y, input logic [9:0] z);
        @(posedge clock); #1;
        accX = x; accY = y; accZ = z; sampleStrobe = 1'b1;
        @(posedge clock); #1;
        sampleStrobe = 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic seq5(input logic [9:0] yd, input logic [9:0] ys);
        ev(Z0, yd, FR); ev(Z0, yd, FR); ev(Z0, ys, FR); ev(Z0, yd, FR); ev(Z0, yd, FR);
    endtask

    // ****************************************
    // test sequence
    // ****************************************
    logic [9:0] tx [4] = '{Z0, P, N, Z0};
    logic [9:0] ty [4] = '{N, Z0, Z0, P};
    initial begin
        repeat (6) @(posedge clock);
        #1 rst = 1'b0;
        rdc(odu_pkg::ADDR_STATUS, 8'h00);
        rdc(odu_pkg::ADDR_CONFIG, 8'h80);
        rdc(odu_pkg::ADDR_DEBOUNCE, 8'h00);
        rdc(8'h13, 8'h00);
        wr(odu_pkg::ADDR_CONFIG, 8'hFF);
        rdc(odu_pkg::ADDR_CONFIG, 8'hC0);
        wr(odu_pkg::ADDR_DEBOUNCE, 8'hA5);
        rdc(odu_pkg::ADDR_DEBOUNCE, 8'hA5);
        wr(odu_pkg::ADDR_STATUS, 8'hFF);
        rdc(odu_pkg::ADDR_STATUS, 8'h00);
        wr(odu_pkg::ADDR_DEBOUNCE, 8'h00);
        sysMode = odu_pkg::SYS_WAKE;
        ev(Z0, P, Z0);
        chk1(orientIrqSource, 1'b1);
        rdc(odu_pkg::ADDR_STATUS, 8'h80);
        chk1(orientIrqSource, 1'b0);
        rdc(odu_pkg::ADDR_STATUS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ev(tx[i], ty[i], FR);
            rdc(odu_pkg::ADDR_STATUS, {1'b1, 4'h0, 2'(i + 1), 1'b0});
        end
        ev(Z0, P, BK);
        ev(P, Z0, BK);
        rdc(odu_pkg::ADDR_STATUS, 8'h85);
        ev(Z0, P, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h80);
        ev(Z0, Z0, P);
        rdc(odu_pkg::ADDR_STATUS, 8'hC0);
        ev(Z0, P, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h80);
        ev(OV, Z0, Z0);
        ev(Z0, N, OV);
        rdc(odu_pkg::ADDR_STATUS, 8'h00);
        wr(odu_pkg::ADDR_DEBOUNCE, 8'h02);
        wr(odu_pkg::ADDR_CONFIG, 8'h40);
        seq5(N, P);
        rdc(odu_pkg::ADDR_STATUS, 8'h82);
        wr(odu_pkg::ADDR_CONFIG, 8'hC0);
        seq5(P, N);
        rdc(odu_pkg::ADDR_STATUS, 8'h02);
        ev(Z0, P, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h80);
        ev(Z0, N, FR);
        ev(Z0, N, FR);
        sysMode = odu_pkg::SYS_SLEEP;
        ev(Z0, N, FR);
        ev(Z0, N, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h00);
        ev(Z0, N, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h82);
        wr(odu_pkg::ADDR_DEBOUNCE, 8'h00);
        sysMode = odu_pkg::SYS_STANDBY;
        outputSampleRate = 3'h1;
        ev(Z0, P, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h02);
        sysMode = odu_pkg::SYS_WAKE;
        ev(Z0, P, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h02);
        ev(Z0, P, FR);
        orientIrqEnable = 1'b0;
        @(posedge clock); #1;
        chk1(orientIrqSource, 1'b0);
        orientIrqEnable = 1'b1;
        #1 chk1(orientIrqSource, 1'b1);
        rdc(odu_pkg::ADDR_STATUS, 8'h80);
        overSampleMode = odu_pkg::OS_HIGHRES;
        outputSampleRate = 3'h3;
        ev(Z0, N, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h00);
        ev(Z0, N, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h82);
        wr(odu_pkg::ADDR_CONFIG, 8'h80);
        ev(Z0, P, FR);
        ev(Z0, P, FR);
        rdc(odu_pkg::ADDR_STATUS, 8'h02);
        end_of_test;
    end

    initial begin
        #50000;
        mismatches++;
        end_of_test;
    end
endmodule

bind odu_top odu_monitor u_mon (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .sysMode(sysMode), .outputSampleRate(outputSampleRate), .overSampleMode(overSampleMode),
    .sampleStrobe(sampleStrobe), .accX(accX), .accY(accY), .accZ(accZ),
    .orientIrqEnable(orientIrqEnable), .orientIrqSource(orientIrqSource));
`default_nettype wire
